// ### include/cpm_pkg.sv
// How it works
// [RULE1] External reset returns every programmable register to its default value.
// [RULE2] The controller holds reset low at least 500 ns at power-on.
// [RULE3] Register writes are accepted and kept while powered down.
// [RULE4] At power-up, power control bit 1 picks differential or single-ended earpiece.
// [RULE5] Clearing power bit 0 powers down; gain bit 7 picks deep or light.
// [RULE6] No master clock transitions forces power-down with serial output released.
// [RULE7] A power-down during a word waits until the word is fully shifted.
// [RULE8] Gain bit 7 high powers down regardless of master clock presence; here bit 7 high only stops clock loss from forcing power-down.
// [RULE9] Samples are 15-bit linear or 8-bit companded, mu-law or A-law.
// [RULE10] Bits launch on bit clock rise; output released after last falling edge.
// [RULE11] Receive bits are held around and sampled on bit clock falling edges.
// [RULE12] The far end gives 16 or 256 bit clocks per frame.
// [RULE13] Clock loss is declared after a fixed edgeless timeout, cleared on edges.
package cpm_pkg;
  localparam int CLK_MHZ = 100;
  localparam int RESET_MIN_NS = 500;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;

  // Register addresses
  localparam logic [1:0] ADDR_PWR_CTL = 2'h0;
  localparam logic [1:0] ADDR_TX_GAIN = 2'h1;
  localparam logic [1:0] ADDR_FORMAT = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;

  // Field positions
  localparam int PWR_ON_BIT = 0;
  localparam int PWR_EAR_DIFF_BIT = 1;
  localparam int PWR_EAR_MUTE_BIT = 3;
  localparam int PWR_MIC_MUTE_BIT = 6;
  localparam int PWR_ST_MUTE_BIT = 7;
  localparam int TXG_DEEP_BIT = 7;
  localparam int FMT_COMP_BIT = 0;
  localparam int FMT_ALAW_BIT = 1;
  localparam int ST_POWERED_BIT = 0;
  localparam int ST_DEEP_BIT = 1;
  localparam int ST_MCLK_LOST_BIT = 2;
  localparam int ST_BUSY_BIT = 3;

  // Reset values
  localparam logic [7:0] PWR_CTL_RST = 8'h00;
  localparam logic [7:0] TX_GAIN_RST = 8'h0B;
  localparam logic [7:0] FORMAT_RST = 8'h00;

  // Word lengths in bits
  localparam logic [3:0] WORD_LIN = 4'hF;
  localparam logic [3:0] WORD_COMP = 4'h8;

  // Master clock loss timeout
  localparam int MCLK_LOSS_NS = 31250;
  localparam int MCLK_LOSS_CYC = (MCLK_LOSS_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] MCLK_LOSS_CNT = 12'(MCLK_LOSS_CYC);

  typedef enum logic [1:0] {
    PS_DOWN_LIGHT = 2'h0,
    PS_ACTIVE = 2'h1,
    PS_DRAIN = 2'h3,
    PS_DOWN_DEEP = 2'h2
  } cpm_pwr_state_t;
endpackage

// ### include/cpm_comp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cpm_comp_if;
  logic [14:0] sample;
  logic companded;
  logic a_law;
  logic [14:0] code;
  modport src(output sample, output companded, output a_law, input code);
  modport enc(input sample, input companded, input a_law, output code);
endinterface
`default_nettype wire

// ### verilog/cpm_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cpm_sync (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign o_level = sync_ff;
  assign o_rise = sync_ff && !last_ff;
  assign o_fall = !sync_ff && last_ff;
endmodule
`default_nettype wire

// ### verilog/cpm_compander.sv
`timescale 1ns/100ps
`default_nettype none
module cpm_compander (
  cpm_comp_if.enc cif
);
  function automatic logic [7:0] mulaw_enc(input logic [14:0] s);
    logic sgn;
    logic [13:0] mag;
    logic [2:0] seg;
    logic [3:0] mant;
    sgn = s[14];
    mag = {1'b0, (sgn ? ~s[13:1] : s[13:1])} + 14'h0021;
    if (mag[13]) begin
      mag = 14'h1FFF;
    end
    seg = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (mag[i + 5]) begin
        seg = 3'(i);
      end
    end
    mant = 4'(mag >> ({1'b0, seg} + 4'h1));
    return ~{sgn, seg, mant};
  endfunction

  function automatic logic [7:0] alaw_enc(input logic [14:0] s);
    logic sgn;
    logic [11:0] mag;
    logic [2:0] seg;
    logic [3:0] mant;
    sgn = s[14];
    mag = sgn ? ~s[13:2] : s[13:2];
    seg = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (mag[i + 4]) begin
        seg = 3'(i);
      end
    end
    mant = 4'(mag >> ((seg == 3'h0) ? 3'h1 : seg));
    return {~sgn, seg, mant} ^ 8'h55;
  endfunction

  // Companded codes sit left-aligned so the shifter always sends the MSB first
  // [RULE9] Format selection
  always_comb begin
    if (!cif.companded) begin
      cif.code = cif.sample;
    end else if (cif.a_law) begin
      cif.code = {alaw_enc(cif.sample), 7'h00};
    end else begin
      cif.code = {mulaw_enc(cif.sample), 7'h00};
    end
  end
endmodule
`default_nettype wire

// ### verilog/cpm_power_ctrl.sv
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module cpm_power_ctrl (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic [1:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA,
  input wire logic I_MCLK,
  input wire logic I_PCM_BIT_CLOCK,
  input wire logic I_PCM_FRAME_SYNC,
  input wire logic I_PCM_SERIAL_IN,
  output logic O_PCM_SERIAL_OUT,
  output logic O_PCM_SERIAL_OUT_OE_N,
  input wire logic [14:0] I_TX_SAMPLE,
  output logic [14:0] O_RX_WORD,
  output logic O_RX_VALID,
  output logic O_DIFF_EAR_EN,
  output logic O_SE_EAR_EN,
  output logic O_EAR_MUTE,
  output logic O_MIC_MUTE,
  output logic O_SIDETONE_MUTE,
  output logic O_POWERED,
  output logic O_DEEP_SLEEP,
  output logic O_MCLK_LOST
);
  logic [7:0] pwr_ctl_ff;
  logic [7:0] tx_gain_ff;
  logic [7:0] format_ff;
  logic [7:0] rdata_ff;
  cpm_pkg::cpm_pwr_state_t state_ff;
  cpm_pkg::cpm_pwr_state_t nxt_state;
  logic [11:0] mclk_cnt_ff;
  logic mclk_lost_ff;
  logic busy_ff;
  logic oe_n_ff;
  logic out_ff;
  logic [14:0] tx_shift_ff;
  logic [14:0] rx_shift_ff;
  logic [3:0] len_ff;
  logic [3:0] cnt_ff;
  logic [14:0] rx_word_ff;
  logic rx_valid_ff;
  logic diff_ear_ff;
  logic se_ear_ff;
  logic mclk_rise;
  logic mclk_fall;
  logic bclk_rise;
  logic bclk_fall;
  logic fsync_level;
  logic rx_level;
  logic powered;
  logic override;
  logic pd_req;
  logic start;
  logic launch;
  logic sample_rx;
  logic last_bit;

  cpm_comp_if cif ();

  cpm_sync u_sync_mclk (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_async(I_MCLK),
    .o_level(),
    .o_rise(mclk_rise),
    .o_fall(mclk_fall)
  );

  cpm_sync u_sync_bclk (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_async(I_PCM_BIT_CLOCK),
    .o_level(),
    .o_rise(bclk_rise),
    .o_fall(bclk_fall)
  );

  cpm_sync u_sync_fsync (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_async(I_PCM_FRAME_SYNC),
    .o_level(fsync_level),
    .o_rise(),
    .o_fall()
  );

  cpm_sync u_sync_rx (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_async(I_PCM_SERIAL_IN),
    .o_level(rx_level),
    .o_rise(),
    .o_fall()
  );

  assign cif.sample = I_TX_SAMPLE;
  assign cif.companded = format_ff[cpm_pkg::FMT_COMP_BIT];
  assign cif.a_law = format_ff[cpm_pkg::FMT_ALAW_BIT];

  cpm_compander u_comp (
    .cif(cif.enc)
  );

  // Registers; writes land in any power state
  // [RULE1] Defaults on reset
  // [RULE3] Writes while down
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      pwr_ctl_ff <= cpm_pkg::PWR_CTL_RST;
      tx_gain_ff <= cpm_pkg::TX_GAIN_RST;
      format_ff <= cpm_pkg::FORMAT_RST;
    end else if (I_REG_WR) begin
      unique case (I_REG_ADDR)
        cpm_pkg::ADDR_PWR_CTL: begin
          pwr_ctl_ff <= I_REG_WDATA;
        end
        cpm_pkg::ADDR_TX_GAIN: begin
          tx_gain_ff <= I_REG_WDATA;
        end
        cpm_pkg::ADDR_FORMAT: begin
          format_ff <= {6'h00, I_REG_WDATA[1:0]};
        end
        cpm_pkg::ADDR_STATUS: begin
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N || !I_REG_RD) begin
      rdata_ff <= 8'h00;
    end else begin
      unique case (I_REG_ADDR)
        cpm_pkg::ADDR_PWR_CTL: begin
          rdata_ff <= pwr_ctl_ff;
        end
        cpm_pkg::ADDR_TX_GAIN: begin
          rdata_ff <= tx_gain_ff;
        end
        cpm_pkg::ADDR_FORMAT: begin
          rdata_ff <= format_ff;
        end
        cpm_pkg::ADDR_STATUS: begin
          rdata_ff <= {4'h0, busy_ff, mclk_lost_ff, (state_ff == cpm_pkg::PS_DOWN_DEEP), powered};
        end
      endcase
    end
  end

  // [RULE13] Edgeless timeout detector
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N || mclk_rise || mclk_fall) begin
      mclk_cnt_ff <= 12'h000;
      mclk_lost_ff <= 1'b0;
    end else if (mclk_cnt_ff == cpm_pkg::MCLK_LOSS_CNT) begin
      mclk_lost_ff <= 1'b1;
    end else begin
      mclk_cnt_ff <= mclk_cnt_ff + 12'h001;
    end
  end

  assign powered = (state_ff == cpm_pkg::PS_ACTIVE) || (state_ff == cpm_pkg::PS_DRAIN);
  assign override = tx_gain_ff[cpm_pkg::TXG_DEEP_BIT];
  // [RULE6] Clock loss forces down unless overridden
  // [RULE8] Override ignores clock detection
  assign pd_req = !pwr_ctl_ff[cpm_pkg::PWR_ON_BIT] || (mclk_lost_ff && !override);

  // [RULE5] Power-down and depth selection
  // [RULE7] Drain a word in flight
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      cpm_pkg::PS_ACTIVE: begin
        if (pd_req && busy_ff) begin
          nxt_state = cpm_pkg::PS_DRAIN;
        end else if (pd_req) begin
          nxt_state = override ? cpm_pkg::PS_DOWN_DEEP : cpm_pkg::PS_DOWN_LIGHT;
        end
      end
      cpm_pkg::PS_DRAIN: begin
        if (!busy_ff && !pd_req) begin
          nxt_state = cpm_pkg::PS_ACTIVE;
        end else if (!busy_ff) begin
          nxt_state = override ? cpm_pkg::PS_DOWN_DEEP : cpm_pkg::PS_DOWN_LIGHT;
        end
      end
      cpm_pkg::PS_DOWN_LIGHT: begin
        if (!pd_req) begin
          nxt_state = cpm_pkg::PS_ACTIVE;
        end else if (override) begin
          nxt_state = cpm_pkg::PS_DOWN_DEEP;
        end
      end
      cpm_pkg::PS_DOWN_DEEP: begin
        if (!pd_req) begin
          nxt_state = cpm_pkg::PS_ACTIVE;
        end else if (!override) begin
          nxt_state = cpm_pkg::PS_DOWN_LIGHT;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      state_ff <= cpm_pkg::PS_DOWN_LIGHT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // [RULE4] Earpiece amplifier choice
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      diff_ear_ff <= 1'b0;
      se_ear_ff <= 1'b0;
    end else begin
      diff_ear_ff <= powered && pwr_ctl_ff[cpm_pkg::PWR_EAR_DIFF_BIT];
      se_ear_ff <= powered && !pwr_ctl_ff[cpm_pkg::PWR_EAR_DIFF_BIT];
    end
  end

  // New words start only while fully active, never in drain
  assign start = bclk_fall && fsync_level && !busy_ff && (state_ff == cpm_pkg::PS_ACTIVE);
  assign launch = busy_ff && bclk_rise && (cnt_ff != len_ff);
  assign sample_rx = busy_ff && bclk_fall && !oe_n_ff;
  assign last_bit = sample_rx && (cnt_ff == len_ff);

  // [RULE10] Launch on rise, release after last fall
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N || !powered) begin
      busy_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      out_ff <= 1'b0;
      cnt_ff <= 4'h0;
      len_ff <= cpm_pkg::WORD_LIN;
      tx_shift_ff <= 15'h0000;
    end else if (start) begin
      busy_ff <= 1'b1;
      cnt_ff <= 4'h0;
      len_ff <= cif.companded ? cpm_pkg::WORD_COMP : cpm_pkg::WORD_LIN;
      tx_shift_ff <= cif.code;
    end else if (launch) begin
      out_ff <= tx_shift_ff[14];
      tx_shift_ff <= {tx_shift_ff[13:0], 1'b0};
      oe_n_ff <= 1'b0;
      cnt_ff <= cnt_ff + 4'h1;
    end else if (last_bit) begin
      oe_n_ff <= 1'b1;
      busy_ff <= 1'b0;
    end
  end

  // [RULE11] Sample on falling edge
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      rx_shift_ff <= 15'h0000;
      rx_word_ff <= 15'h0000;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= last_bit;
      if (start) begin
        rx_shift_ff <= 15'h0000;
      end else if (sample_rx) begin
        rx_shift_ff <= {rx_shift_ff[13:0], rx_level};
      end
      if (last_bit) begin
        rx_word_ff <= (len_ff == cpm_pkg::WORD_COMP) ? {7'h00, rx_shift_ff[6:0], rx_level} :
                      {rx_shift_ff[13:0], rx_level};
      end
    end
  end

  assign O_REG_RDATA = rdata_ff;
  assign O_PCM_SERIAL_OUT = out_ff;
  assign O_PCM_SERIAL_OUT_OE_N = oe_n_ff;
  assign O_RX_WORD = rx_word_ff;
  assign O_RX_VALID = rx_valid_ff;
  assign O_DIFF_EAR_EN = diff_ear_ff;
  assign O_SE_EAR_EN = se_ear_ff;
  assign O_EAR_MUTE = pwr_ctl_ff[cpm_pkg::PWR_EAR_MUTE_BIT];
  assign O_MIC_MUTE = pwr_ctl_ff[cpm_pkg::PWR_MIC_MUTE_BIT];
  assign O_SIDETONE_MUTE = pwr_ctl_ff[cpm_pkg::PWR_ST_MUTE_BIT];
  assign O_POWERED = powered;
  assign O_DEEP_SLEEP = (state_ff == cpm_pkg::PS_DOWN_DEEP);
  assign O_MCLK_LOST = mclk_lost_ff;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  a_reset_defaults: assert property ($past(!I_RESET_N) |-> pwr_ctl_ff == cpm_pkg::PWR_CTL_RST && // [RULE1]
    tx_gain_ff == cpm_pkg::TX_GAIN_RST && format_ff == cpm_pkg::FORMAT_RST && !O_POWERED)
    else $error("registers not at defaults after reset");

  a_write_while_down: assert property (I_REG_WR && I_REG_ADDR == cpm_pkg::ADDR_TX_GAIN && !powered // [RULE3]
    |=> (tx_gain_ff == $past(I_REG_WDATA) && !powered) ##1 !powered)
    else $error("write lost while powered down");

  a_ear_choice: assert property (state_ff == cpm_pkg::PS_ACTIVE |=> // [RULE4]
    O_DIFF_EAR_EN == $past(pwr_ctl_ff[1]) && O_SE_EAR_EN == !$past(pwr_ctl_ff[1]))
    else $error("wrong earpiece amplifier enabled");

  a_idle_power_down: assert property (state_ff == cpm_pkg::PS_ACTIVE && !pwr_ctl_ff[0] && !busy_ff // [RULE5]
    |=> O_DEEP_SLEEP == $past(override) && !O_POWERED)
    else $error("power bit clear did not power down");

  a_clock_loss_hiz: assert property (mclk_lost_ff && !override && !busy_ff // [RULE6]
    |-> ##[1:2] (O_PCM_SERIAL_OUT_OE_N && !O_POWERED))
    else $error("clock loss did not release output");

  a_word_drains: assert property (state_ff == cpm_pkg::PS_ACTIVE && pd_req && busy_ff // [RULE7]
    |=> state_ff == cpm_pkg::PS_DRAIN && O_POWERED)
    else $error("busy word cut by power down");

  a_override_ignores: assert property (state_ff == cpm_pkg::PS_ACTIVE && pwr_ctl_ff[0] && override // [RULE8]
    |=> state_ff == cpm_pkg::PS_ACTIVE)
    else $error("clock loss acted despite override");

  a_word_length: assert property (start |=> len_ff == ($past(format_ff[0]) ? 4'h8 : 4'hF)) // [RULE9]
    else $error("word length does not match format");

  a_launch_rise: assert property ($fell(O_PCM_SERIAL_OUT_OE_N) |-> $past(bclk_rise)) // [RULE10]
    else $error("output driven without bit clock rise");

  a_release_fall: assert property ($rose(O_PCM_SERIAL_OUT_OE_N) |-> $past(bclk_fall) || !$past(powered)) // [RULE10]
    else $error("output released off a falling edge");

  a_sample_fall: assert property (O_RX_VALID |-> $past(bclk_fall) && O_PCM_SERIAL_OUT_OE_N) // [RULE11]
    else $error("receive word completed off a falling edge");

  a_loss_timeout: assert property ((mclk_rise || mclk_fall) |=> !mclk_lost_ff [*8]) // [RULE13]
    else $error("clock loss flagged right after an edge");

  c_word_done: cover property (O_RX_VALID);
  c_drain_seen: cover property (state_ff == cpm_pkg::PS_DRAIN ##[1:1000] !powered);
  c_deep_sleep: cover property (state_ff == cpm_pkg::PS_DOWN_DEEP);
  c_clock_lost: cover property ($rose(mclk_lost_ff));
endmodule
`default_nettype wire

// ### dv/cpm_bb_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpm_bb_model (
  output logic o_mclk,
  output logic o_bit_clock,
  output logic o_frame_sync,
  output logic o_serial_in,
  input wire logic i_serial_out,
  input wire logic i_serial_out_oe_n
);
  logic mclk_on;
  logic [14:0] tx_word;
  int tx_cnt;

  initial begin
    mclk_on = 1'b1;
    o_mclk = 1'b0;
    o_bit_clock = 1'b0;
    o_frame_sync = 1'b0;
    o_serial_in = 1'b1;
    tx_word = 15'h0000;
    tx_cnt = 0;
  end

  always #250 if (mclk_on) o_mclk = ~o_mclk;

  // Bit clock stands low between frames
  // Sixteen clocks per frame
  task automatic frame(input int nbits, input logic [14:0] rx);
    tx_word = 15'h0000;
    tx_cnt = 0;
    o_frame_sync = 1'b1;
    #31.25 o_bit_clock = 1'b1;
    #62.5 o_bit_clock = 1'b0;
    #31.25 o_frame_sync = 1'b0;
    for (int k = 1; k < 16; k++) begin
      #31.25 o_bit_clock = 1'b1;
      o_serial_in = (k <= nbits) ? rx[nbits-k] : ~o_serial_in;
      #62.5 o_bit_clock = 1'b0;
      if (i_serial_out_oe_n === 1'b0) begin
        tx_word = {tx_word[13:0], i_serial_out};
        tx_cnt++;
      end
      #31.25;
    end
    // Released line shows no stale bit
    o_serial_in = ~o_serial_in;
  endtask
endmodule
`default_nettype wire

// ### dv/test_codec_power_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_codec_power_mode_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [14:0] tx_sample = 15'h0000;
  wire logic mclk, bclk, fsync, sin;
  logic [7:0] rdata, rv;
  logic sout, oe_n, rx_valid, diff_en, se_en, ear_m, mic_m, st_m, powered, deep, lost;
  logic [14:0] rx_word;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int rx_pulses = 0;

  cpm_power_ctrl cpm_power_ctrl_i (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr_s), .I_REG_RD(rd_s), .O_REG_RDATA(rdata), .I_MCLK(mclk),
    .I_PCM_BIT_CLOCK(bclk), .I_PCM_FRAME_SYNC(fsync), .I_PCM_SERIAL_IN(sin),
    .O_PCM_SERIAL_OUT(sout), .O_PCM_SERIAL_OUT_OE_N(oe_n), .I_TX_SAMPLE(tx_sample),
    .O_RX_WORD(rx_word), .O_RX_VALID(rx_valid), .O_DIFF_EAR_EN(diff_en), .O_SE_EAR_EN(se_en),
    .O_EAR_MUTE(ear_m), .O_MIC_MUTE(mic_m), .O_SIDETONE_MUTE(st_m), .O_POWERED(powered),
    .O_DEEP_SLEEP(deep), .O_MCLK_LOST(lost)
  );

  cpm_bb_model cpm_bb_model_i (
    .o_mclk(mclk), .o_bit_clock(bclk), .o_frame_sync(fsync), .o_serial_in(sin),
    .i_serial_out(sout), .i_serial_out_oe_n(oe_n)
  );

  always #5 clk = ~clk;

  // Receive valid pulses, counted where the output is settled
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      rx_pulses++;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [14:0] seen, input logic [14:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (cpm_pkg::RESET_MIN_CYC) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic t_reset;
    wr(cpm_pkg::ADDR_PWR_CTL, 8'hCB);
    wr(cpm_pkg::ADDR_TX_GAIN, 8'h85);
    wr(cpm_pkg::ADDR_FORMAT, 8'h03);
    do_reset;
    tick(1);
    rd(cpm_pkg::ADDR_PWR_CTL, rv);
    chk("power ctl", 15'(rv), 15'(cpm_pkg::PWR_CTL_RST));
    rd(cpm_pkg::ADDR_TX_GAIN, rv);
    chk("tx gain", 15'(rv), 15'(cpm_pkg::TX_GAIN_RST));
    rd(cpm_pkg::ADDR_FORMAT, rv);
    chk("format", 15'(rv), 15'(cpm_pkg::FORMAT_RST));
    chk("powered", 15'({powered, diff_en, oe_n}), 15'h0001);
    $display("test reset done");
  endtask

  task automatic t_pre;
    wr(cpm_pkg::ADDR_FORMAT, 8'h03);
    wr(cpm_pkg::ADDR_TX_GAIN, 8'h7A);
    wr(cpm_pkg::ADDR_PWR_CTL, 8'h02);
    wr(cpm_pkg::ADDR_STATUS, 8'hFF);
    rd(cpm_pkg::ADDR_FORMAT, rv);
    chk("format", 15'(rv), 15'h0003);
    rd(cpm_pkg::ADDR_TX_GAIN, rv);
    chk("tx gain", 15'(rv), 15'h007A);
    rd(cpm_pkg::ADDR_PWR_CTL, rv);
    chk("power ctl", 15'(rv), 15'h0002);
    rd(cpm_pkg::ADDR_STATUS, rv);
    chk("status", 15'(rv), 15'h0000);
    chk("still down", 15'(powered), 15'h0000);
    $display("test setup while down done");
  endtask

  task automatic t_ear;
    wr(cpm_pkg::ADDR_PWR_CTL, 8'hCB);
    tick(3);
    chk("diff ear", 15'({diff_en, se_en}), 15'h0002);
    chk("mutes", 15'({ear_m, mic_m, st_m}), 15'h0007);
    wr(cpm_pkg::ADDR_PWR_CTL, 8'h09);
    tick(3);
    chk("single ear", 15'({diff_en, se_en}), 15'h0001);
    $display("test earpiece done");
  endtask

  task automatic t_pd;
    wr(cpm_pkg::ADDR_TX_GAIN, 8'h0B);
    wr(cpm_pkg::ADDR_PWR_CTL, 8'h00);
    tick(3);
    chk("light down", 15'({powered, deep}), 15'h0000);
    wr(cpm_pkg::ADDR_TX_GAIN, 8'h8B);
    tick(3);
    chk("deep down", 15'({powered, deep}), 15'h0001);
    rd(cpm_pkg::ADDR_STATUS, rv);
    chk("status", 15'(rv), 15'h0002);
    $display("test power down done");
  endtask

  task automatic t_frame(input logic [7:0] fmt, input int nbits, input logic [14:0] tx, input logic [14:0] exp_tx,
                         input logic [14:0] rx);
    int p;
    wr(cpm_pkg::ADDR_FORMAT, fmt);
    wr(cpm_pkg::ADDR_PWR_CTL, 8'h01);
    @(posedge clk);
    tx_sample <= tx;
    tick(4);
    p = rx_pulses;
    cpm_bb_model_i.frame(nbits, rx);
    tick(4);
    chk("rx valid pulses", 15'(rx_pulses - p), 15'h0001);
    chk("bit count", 15'(cpm_bb_model_i.tx_cnt), 15'(nbits));
    chk("rx word", rx_word, (nbits == 15) ? rx : {7'h00, rx[7:0]});
    chk("tx word", cpm_bb_model_i.tx_word, exp_tx);
    chk("released", 15'(oe_n), 15'h0001);
    $display("test frame %0d bits done", nbits);
  endtask

  task automatic t_drain;
    wr(cpm_pkg::ADDR_FORMAT, 8'h00);
    wr(cpm_pkg::ADDR_PWR_CTL, 8'h01);
    @(posedge clk);
    tx_sample <= 15'h7FFF;
    tick(4);
    fork
      cpm_bb_model_i.frame(15, 15'h0001);
      begin
        #600;
        wr(cpm_pkg::ADDR_PWR_CTL, 8'h00);
        tick(2);
        chk("powered in word", 15'(powered), 15'h0001);
      end
    join
    tick(8);
    chk("drained bits", 15'(cpm_bb_model_i.tx_cnt), 15'h000F);
    chk("drained word", cpm_bb_model_i.tx_word, 15'h7FFF);
    chk("down after word", 15'(powered), 15'h0000);
    $display("test drain done");
  endtask

  task automatic t_mclk(input logic [7:0] gain, input logic exp_pwr);
    wr(cpm_pkg::ADDR_TX_GAIN, gain);
    wr(cpm_pkg::ADDR_PWR_CTL, 8'h01);
    cpm_bb_model_i.mclk_on = 1'b0;
    tick(cpm_pkg::MCLK_LOSS_CYC + 60);
    chk("clock lost", 15'(lost), 15'h0001);
    chk("powered no clock", 15'(powered), 15'(exp_pwr));
    chk("out released", 15'(oe_n), 15'h0001);
    rd(cpm_pkg::ADDR_STATUS, rv);
    chk("status lost", 15'(rv), 15'h0004 | 15'(exp_pwr));
    cpm_bb_model_i.mclk_on = 1'b1;
    tick(40);
    chk("clock back", 15'(lost), 15'h0000);
    chk("powered again", 15'(powered), 15'h0001);
    $display("test clock loss done");
  endtask

  initial begin
    do_reset;
    t_reset;
    t_pre;
    t_ear;
    t_pd;
    t_frame(8'h00, 15, 15'h5A3C, 15'h5A3C, 15'h4D21);
    t_frame(8'h00, 15, 15'h4000, 15'h4000, 15'h3FFF);
    t_frame(8'h01, 8, 15'h1234, 15'h009D, 15'h00A5);
    t_frame(8'h03, 8, 15'h6543, 15'h003F, 15'h005A);
    t_drain;
    t_mclk(8'h0B, 1'b0);
    t_mclk(8'h8B, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire
